// *** include/xcvr_defs.svh ***
/*
 constants of the 18-bit latched bus transceiver: data width and reset value of the stores.
 assumes inclusion by bare name from the package and the rtl files.
*/
`ifndef XCVR_DEFS_SVH
`define XCVR_DEFS_SVH
`define XCVR_DATA_W     18
`define XCVR_STORE_RST  18'h00000
`endif

// *** include/xcvr_pkg.sv ***
/*
 types of the transceiver: per-direction control group and storage mode.
 assumes xcvr_defs.svh on the include path.
*/
`default_nettype none
`include "xcvr_defs.svh"
package xcvr_pkg;
	typedef struct packed {
		logic output_enable_n;
		logic latch_enable;
		logic clock;
		logic clock_enable_n;
	} xcvr_ctrl_t;

	typedef enum logic [1:0] {
		XCVR_TRANSPARENT,
		XCVR_HOLD,
		XCVR_CAPTURE
	} xcvr_mode_t;
endpackage : xcvr_pkg
`default_nettype wire

// *** rtl/xcvr_path.sv ***
/*
 one direction of the transceiver: latch/flip-flop store and 3-state driver.
 assumes synchronous control inputs sampled on clk and a reset already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_defs.svh"
module xcvr_path
	import xcvr_pkg::*;
#(
	parameter int W = `XCVR_DATA_W
)(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire xcvr_pkg::xcvr_ctrl_t ctrl,
	input  wire logic [W-1:0]      data_in,
	output var  logic [W-1:0]      data_out,
	output var  logic [W-1:0]      data_oe,
	output var  xcvr_pkg::xcvr_mode_t mode
);
	logic             clock_q;
	logic             next_clock_q;
	logic [W-1:0]     store;
	logic [W-1:0]     next_store;
	logic [W-1:0]     next_data_out;
	logic [W-1:0]     next_data_oe;
	xcvr_mode_t       next_mode;

	function automatic logic rise(input logic prev, input logic now);
		return !prev && now;
	endfunction : rise

	always_comb
	begin
		next_clock_q = ctrl.clock;
		next_store = store;
		if (ctrl.latch_enable)
		begin
			next_store = data_in;
			next_mode = XCVR_TRANSPARENT;
		end
		else if (!ctrl.clock_enable_n && rise(clock_q, ctrl.clock))
		begin
			next_store = data_in;
			next_mode = XCVR_CAPTURE;
		end
		else
		begin
			next_mode = XCVR_HOLD;
		end
		next_data_out = next_store;
		// disable wins over every store mode
		next_data_oe = ctrl.output_enable_n ? '0 : '1;
	end

	// store has no documented reset; zero is only a defined start
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clock_q  <= 1'b0;
			store    <= `XCVR_STORE_RST;
			data_out <= `XCVR_STORE_RST;
			data_oe  <= '0;
			mode     <= XCVR_HOLD;
		end
		else
		begin
			clock_q  <= next_clock_q;
			store    <= next_store;
			data_out <= next_data_out;
			data_oe  <= next_data_oe;
			mode     <= next_mode;
		end
	end

	chk_transparent_pass: assert property (@(posedge clk) disable iff (!rst_n)
		ctrl.latch_enable |=> data_out == $past(data_in)) else $error("transparent path wrong");
	chk_hold_steady: assert property (@(posedge clk) disable iff (!rst_n)
		(!ctrl.latch_enable && ctrl.clock == clock_q) |=> data_out == $past(data_out))
		else $error("held data changed");
	chk_edge_capture: assert property (@(posedge clk) disable iff (!rst_n)
		(!ctrl.latch_enable && !ctrl.clock_enable_n && ctrl.clock && !clock_q) |=> data_out == $past(data_in))
		else $error("edge capture missed");
	chk_gated_edge: assert property (@(posedge clk) disable iff (!rst_n)
		(!ctrl.latch_enable && ctrl.clock_enable_n) |=> data_out == $past(data_out))
		else $error("gated clock changed data");
	chk_drive_on: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrl.output_enable_n |=> data_oe == '1) else $error("outputs not driven");
	chk_drive_off: assert property (@(posedge clk) disable iff (!rst_n)
		ctrl.output_enable_n |=> data_oe == '0) else $error("outputs not released");
	cov_transparent: cover property (@(posedge clk) disable iff (!rst_n) mode == XCVR_TRANSPARENT);
	cov_capture: cover property (@(posedge clk) disable iff (!rst_n) mode == XCVR_CAPTURE);
	cov_hold_then_cap: cover property (@(posedge clk) disable iff (!rst_n)
		mode == XCVR_HOLD ##1 mode == XCVR_CAPTURE);
endmodule : xcvr_path
`default_nettype wire

// *** rtl/xcvr_top.sv ***
/*
 18-bit two-way latched bus transceiver, A side and B side: reset release and the two store paths.
 assumes all control inputs synchronous to CLK_I; pad logic resolves enables to wires.
 assumes the store clocks hold each level for at least one CLK_I cycle, else an edge is missed.
*/
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_defs.svh"
module xcvr_top
	import xcvr_pkg::*;
#(
	parameter int W = `XCVR_DATA_W
)(
	input  wire logic         CLK_I,
	input  wire logic         RESETN_I,
	input  wire logic         A_TO_B_OUTPUT_ENABLE_N_I,
	input  wire logic         A_TO_B_LATCH_ENABLE_I,
	input  wire logic         A_TO_B_CLOCK_I,
	input  wire logic         A_TO_B_CLOCK_ENABLE_N_I,
	input  wire logic         B_TO_A_OUTPUT_ENABLE_N_I,
	input  wire logic         B_TO_A_LATCH_ENABLE_I,
	input  wire logic         B_TO_A_CLOCK_I,
	input  wire logic         B_TO_A_CLOCK_ENABLE_N_I,
	input  wire logic [W-1:0] A_I,
	output var  logic [W-1:0] A_O,
	output var  logic [W-1:0] A_OE_O,
	input  wire logic [W-1:0] B_I,
	output var  logic [W-1:0] B_O,
	output var  logic [W-1:0] B_OE_O
);
	logic       rst_meta;
	logic       rst_n;
	logic       next_rst_meta;
	logic       next_rst_n;
	xcvr_ctrl_t ab_ctrl;
	xcvr_ctrl_t ba_ctrl;
	xcvr_mode_t ab_mode;
	xcvr_mode_t ba_mode;
	logic       ab_clock_seen;
	logic       ba_clock_seen;
	logic       next_ab_clock_seen;
	logic       next_ba_clock_seen;

	// release delayed two edges so no path leaves reset on a half-settled edge
	always_comb
	begin
		next_rst_meta = 1'b1;
		next_rst_n    = rst_meta;
	end

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= next_rst_meta;
			rst_n    <= next_rst_n;
		end
	end

	// fields by name: a positional pattern would swap pins silently if the struct changed
	always_comb
	begin
		ab_ctrl.output_enable_n = A_TO_B_OUTPUT_ENABLE_N_I;
		ab_ctrl.latch_enable    = A_TO_B_LATCH_ENABLE_I;
		ab_ctrl.clock           = A_TO_B_CLOCK_I;
		ab_ctrl.clock_enable_n  = A_TO_B_CLOCK_ENABLE_N_I;
		ba_ctrl.output_enable_n = B_TO_A_OUTPUT_ENABLE_N_I;
		ba_ctrl.latch_enable    = B_TO_A_LATCH_ENABLE_I;
		ba_ctrl.clock           = B_TO_A_CLOCK_I;
		ba_ctrl.clock_enable_n  = B_TO_A_CLOCK_ENABLE_N_I;
	end

	// pin-side copy of the last sampled store clocks, read by the checks only
	always_comb
	begin
		next_ab_clock_seen = A_TO_B_CLOCK_I;
		next_ba_clock_seen = B_TO_A_CLOCK_I;
	end

	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ab_clock_seen <= 1'b0;
			ba_clock_seen <= 1'b0;
		end
		else
		begin
			ab_clock_seen <= next_ab_clock_seen;
			ba_clock_seen <= next_ba_clock_seen;
		end
	end

	// outputs are flops inside each path
	xcvr_path #(.W(W)) u_a_to_b (
		.clk      (CLK_I),
		.rst_n    (rst_n),
		.ctrl     (ab_ctrl),
		.data_in  (A_I),
		.data_out (B_O),
		.data_oe  (B_OE_O),
		.mode     (ab_mode)
	);

	xcvr_path #(.W(W)) u_b_to_a (
		.clk      (CLK_I),
		.rst_n    (rst_n),
		.ctrl     (ba_ctrl),
		.data_in  (B_I),
		.data_out (A_O),
		.data_oe  (A_OE_O),
		.mode     (ba_mode)
	);

	// floated outputs while the internal reset is held
	chk_reset_float: assert property (@(posedge CLK_I)
		!rst_n
		|=> (A_OE_O == '0 && B_OE_O == '0))
		else $error("outputs driven during reset");

	// a-to-b as seen at the pins
	chk_ab_pass_pins: assert property (@(posedge CLK_I) disable iff (!rst_n)
		A_TO_B_LATCH_ENABLE_I
		|=> B_O == $past(A_I))
		else $error("b side misses the transparent word");

	chk_ab_hold_pins: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(!A_TO_B_LATCH_ENABLE_I && A_TO_B_CLOCK_I == ab_clock_seen)
		|=> $stable(B_O))
		else $error("b side held word changed");

	chk_ab_capture_pins: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(!A_TO_B_LATCH_ENABLE_I && !A_TO_B_CLOCK_ENABLE_N_I && A_TO_B_CLOCK_I && !ab_clock_seen)
		|=> B_O == $past(A_I))
		else $error("b side missed a clock rise");

	chk_ab_gate_pins: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(!A_TO_B_LATCH_ENABLE_I && A_TO_B_CLOCK_ENABLE_N_I)
		|=> $stable(B_O))
		else $error("b side changed with clock gated");

	chk_ab_drive_pins: assert property (@(posedge CLK_I) disable iff (!rst_n)
		!A_TO_B_OUTPUT_ENABLE_N_I
		|=> B_OE_O == '1)
		else $error("b side not driven");

	chk_ab_float_pins: assert property (@(posedge CLK_I) disable iff (!rst_n)
		A_TO_B_OUTPUT_ENABLE_N_I
		|=> B_OE_O == '0)
		else $error("b side not released");

	chk_ab_mode_pass: assert property (@(posedge CLK_I) disable iff (!rst_n)
		ab_mode == XCVR_TRANSPARENT
		|-> B_O == $past(A_I))
		else $error("b side transparent mode wrong word");

	chk_ab_mode_hold: assert property (@(posedge CLK_I) disable iff (!rst_n)
		ab_mode == XCVR_HOLD
		|-> $stable(B_O))
		else $error("b side hold mode changed word");

	chk_ab_mode_cap: assert property (@(posedge CLK_I) disable iff (!rst_n)
		ab_mode == XCVR_CAPTURE
		|-> B_O == $past(A_I))
		else $error("b side capture mode wrong word");

	// b-to-a as seen at the pins
	chk_ba_transparent: assert property (@(posedge CLK_I) disable iff (!rst_n)
		B_TO_A_LATCH_ENABLE_I
		|=> A_O == $past(B_I))
		else $error("b to a transparent wrong");

	chk_ba_release: assert property (@(posedge CLK_I) disable iff (!rst_n)
		B_TO_A_OUTPUT_ENABLE_N_I
		|=> A_OE_O == '0)
		else $error("a side not released");

	chk_ba_drive_pins: assert property (@(posedge CLK_I) disable iff (!rst_n)
		!B_TO_A_OUTPUT_ENABLE_N_I
		|=> A_OE_O == '1)
		else $error("a side not driven");

	chk_ba_hold_pins: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(!B_TO_A_LATCH_ENABLE_I && B_TO_A_CLOCK_I == ba_clock_seen)
		|=> $stable(A_O))
		else $error("a side held word changed");

	chk_ba_capture_pins: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(!B_TO_A_LATCH_ENABLE_I && !B_TO_A_CLOCK_ENABLE_N_I && B_TO_A_CLOCK_I && !ba_clock_seen)
		|=> A_O == $past(B_I))
		else $error("a side missed a clock rise");

	chk_ba_gate_pins: assert property (@(posedge CLK_I) disable iff (!rst_n)
		(!B_TO_A_LATCH_ENABLE_I && B_TO_A_CLOCK_ENABLE_N_I)
		|=> $stable(A_O))
		else $error("a side changed with clock gated");

	chk_ba_mode_pass: assert property (@(posedge CLK_I) disable iff (!rst_n)
		ba_mode == XCVR_TRANSPARENT
		|-> A_O == $past(B_I))
		else $error("a side transparent mode wrong word");

	chk_ba_mode_hold: assert property (@(posedge CLK_I) disable iff (!rst_n)
		ba_mode == XCVR_HOLD
		|-> $stable(A_O))
		else $error("a side hold mode changed word");

	chk_ba_mode_cap: assert property (@(posedge CLK_I) disable iff (!rst_n)
		ba_mode == XCVR_CAPTURE
		|-> A_O == $past(B_I))
		else $error("a side capture mode wrong word");

	cov_both_ways: cover property (@(posedge CLK_I) disable iff (!rst_n)
		A_OE_O == '1 ##1 B_OE_O == '1);
	cov_ba_capture: cover property (@(posedge CLK_I) disable iff (!rst_n)
		ba_mode == XCVR_CAPTURE ##1 ba_mode == XCVR_HOLD);
endmodule : xcvr_top
`default_nettype wire

// *** dv/xcvr_bus_model.sv ***
/*
 far-side bus logic: drives the A and B pads wherever the transceiver floats them.
 assumes per-bit enables high = transceiver drives that bit.
*/
`timescale 1ns/1ps
`default_nettype none
module xcvr_bus_model (
	input  wire logic [17:0] a_o_i,
	input  wire logic [17:0] a_oe_i,
	input  wire logic [17:0] b_o_i,
	input  wire logic [17:0] b_oe_i,
	input  wire logic [17:0] a_word_i,
	input  wire logic [17:0] b_word_i,
	output var  logic [17:0] a_pad_o,
	output var  logic [17:0] b_pad_o
);
	// yields every driven bit, so no wire ever has two drivers
	assign a_pad_o = (a_oe_i & a_o_i) | (~a_oe_i & a_word_i);
	assign b_pad_o = (b_oe_i & b_o_i) | (~b_oe_i & b_word_i);
endmodule : xcvr_bus_model
`default_nettype wire

// *** dv/testbench.sv ***
/*
 random controls on both paths against a reference, notes queued.
 assumes 1-cycle registered outputs, 2-flop reset release.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import xcvr_pkg::*;
	logic        clk = 0;
	logic        rst_n = 0;
	xcvr_ctrl_t  c [2];
	logic [17:0] word [2];
	logic [17:0] pad [2];
	logic [17:0] o [2];
	logic [17:0] oe [2];
	logic [17:0] st [2];
	logic        pc [2];
	logic [31:0] seed = 32'h39c50398;
	logic [71:0] q [$];
	logic [71:0] e;
	int          err_count = 0;
	int          n_compared = 0;
	xcvr_top dut (.CLK_I(clk), .RESETN_I(rst_n),
		.A_TO_B_OUTPUT_ENABLE_N_I(c[0].output_enable_n), .A_TO_B_LATCH_ENABLE_I(c[0].latch_enable),
		.A_TO_B_CLOCK_I(c[0].clock), .A_TO_B_CLOCK_ENABLE_N_I(c[0].clock_enable_n),
		.B_TO_A_OUTPUT_ENABLE_N_I(c[1].output_enable_n), .B_TO_A_LATCH_ENABLE_I(c[1].latch_enable),
		.B_TO_A_CLOCK_I(c[1].clock), .B_TO_A_CLOCK_ENABLE_N_I(c[1].clock_enable_n),
		.A_I(pad[0]), .A_O(o[1]), .A_OE_O(oe[1]), .B_I(pad[1]), .B_O(o[0]), .B_OE_O(oe[0]));
	xcvr_bus_model far (.a_o_i(o[1]), .a_oe_i(oe[1]), .b_o_i(o[0]), .b_oe_i(oe[0]),
		.a_word_i(word[0]), .b_word_i(word[1]), .a_pad_o(pad[0]), .b_pad_o(pad[1]));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic results();
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results
	// one cycle of stimulus at the falling edge, note of the expected outputs
	task automatic step(input bit go);
		logic [31:0] r;
		logic [1:0]  en;
		logic [17:0] sp [2];
		// enables that stand on the pads until the coming edge
		en = {~c[1].output_enable_n, ~c[0].output_enable_n};
		for (int d = 0; d < 2; d++)
		begin
			r = rnd();
			if (c[d].latch_enable && !r[2])
			begin
				r[1] = 1'b0; // clock low when latch enable drops
				r[2] = c[d].clock; // a high clock keeps the latch open one more step
			end
			if (go)
				c[d] = r[3:0];
			word[d] = r[31:14];
		end
		// pad level from the expected outputs, not from the design's
		for (int d = 0; d < 2; d++)
			sp[d] = en[1 - d] ? st[1 - d] : word[d];
		for (int d = 0; d < 2; d++)
		begin
			if (c[d].latch_enable || (!c[d].clock_enable_n && c[d].clock && !pc[d]))
				st[d] = sp[d];
			pc[d] = c[d].clock;
		end
		q.push_back({{18{~c[0].output_enable_n}}, st[0], {18{~c[1].output_enable_n}}, st[1]});
	endtask : step
	initial
	begin
		for (int d = 0; d < 2; d++)
		begin
			c[d] = 4'h8;
			word[d] = '0;
			st[d] = '0;
			pc[d] = 1'b0;
		end
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
	begin
		#10;
		if (q.size() != 0)
		begin
			e = q.pop_front();
			chk("B_OE_O", oe[0], e[71:54]);
			chk("B_O", o[0] & e[71:54], e[53:36] & e[71:54]);
			chk("A_OE_O", oe[1], e[35:18]);
			chk("A_O", o[1] & e[35:18], e[17:0] & e[35:18]);
		end
	end
	initial
	begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 2003; i++)
		begin
			step(i > 2);
			@(negedge clk);
		end
		results();
	end
	initial
	begin
		#300000;
		err_count++;
		results();
	end
endmodule : testbench
`default_nettype wire
